// ===== hw/output_clock_select_consts.svh
/*
   Constants of the output clock selection block: register indices, reset
   values, field positions, selector codes, divide ratios and frame rates.
   Assumes a 200 MHz pclk and an APB bus on which register index n sits at
   byte address 4*n.
*/
// Operation
// - Selector 0, 1, 2: low, 2 kHz, 8 kHz.
// - Codes 0101 to 1010 divide main PLL.
// - Code 1011: aux/2 on four, five; else /64.
// - Codes 1100 to 1111 divide aux PLL.
// - Aux 62.5 MHz lock makes 1100 divide by ten.
// - Code 0011 synth two, 0100 synth one.
// - Output six: 0011 main/2, 0101 main undivided.
// - Output seven: 0100 gives main/2.
// - Selector pairs packed high and low nibble.
// - Bit 7 enables 2 kHz frame output.
// - Bit 6 enables 8 kHz frame output.
// - Bit 5 enables line-rate output.
// - Bit 4 enables composite, else high impedance.
// - Auto-mute forces composite and line low.
// - Output-seven selector in low nibble.
// - Line-rate select bit, reset from strap pin.
// - Aux PLL source bit: aux or main.
// - Aux digital PLL code 1001 is 62.5 MHz.
`ifndef OUTPUT_CLOCK_SELECT_CONSTS_SVH
`define OUTPUT_CLOCK_SELECT_CONSTS_SVH

// ----------------------------------------------------------------------
// Register indices and reset values
// ----------------------------------------------------------------------
`define IDX_OUTPUT_CONFIG_TWO   8'h61
`define IDX_OUTPUT_CONFIG_THREE 8'h62
`define IDX_OUTPUT_CONFIG_FOUR  8'h63
`define IDX_AUX_PLL_CONFIG_ONE  8'h64
`define IDX_MAIN_PLL_CONFIG_ONE 8'h65
`define IDX_MASTER_CONFIG_FOUR  8'h70
`define IDX_OUTPUT_STATUS       8'h71
`define RST_OUTPUT_CONFIG_TWO   8'h86
`define RST_OUTPUT_CONFIG_THREE 8'h8A
`define RST_OUTPUT_CONFIG_FOUR  8'hF6
`define RST_AUX_PLL_CONFIG_ONE  8'h01
`define RST_MAIN_PLL_CONFIG_ONE 8'h01
`define RST_MASTER_CONFIG_FOUR  8'h00
`define AUX_CFG_WRITE_MASK      8'h7F
`define PAIR_CFG_WRITE_MASK     8'h01

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define FRAME_2K_EN_BIT    7
`define FRAME_8K_EN_BIT    6
`define LINE_RATE_EN_BIT   5
`define COMPOSITE_EN_BIT   4
`define AUTO_MUTE_BIT      6
`define DUTY_SEL_BIT       5
`define SONET_SEL_BIT      4
`define AUX_FROM_MAIN_BIT  6
`define PAIR_SOURCE_BIT    0

// ----------------------------------------------------------------------
// Selector codes, ratios and rates
// ----------------------------------------------------------------------
`define SEL_2K          4'h1
`define SEL_8K          4'h2
`define SEL_SYN_TWO     4'h3
`define SEL_SYN_ONE     4'h4
`define SEL_MAIN_48     4'h5
`define SEL_MAIN_16     4'h6
`define SEL_MAIN_12     4'h7
`define SEL_MAIN_8      4'h8
`define SEL_MAIN_6      4'h9
`define SEL_MAIN_4      4'hA
`define SEL_AUX_64      4'hB
`define SEL_AUX_48      4'hC
`define SEL_AUX_16      4'hD
`define SEL_AUX_8       4'hE
`define SEL_AUX_4       4'hF
`define AUX_DPLL_62M5   4'h9
`define COMP_HIGH_HALF  3'h4
`define COMP_HIGH_5_8   3'h5
`define PCLK_HZ         200000000
`define FRAME_2K_HZ     2000
`define FRAME_8K_HZ     8000

`endif

// ===== hw/output_clock_select_pkg.sv
/*
   Types of the output clock selection block.
   Assumes the constants header is compiled alongside.
*/
package output_clock_select_pkg;

   typedef enum logic [2:0] {
      SRC_LOW, SRC_2K, SRC_8K, SRC_SYN_ONE, SRC_SYN_TWO, SRC_MAIN, SRC_AUX
   } src_kind_t;

   typedef struct packed {
      src_kind_t   kind;
      logic [15:0] ratio;
   } route_t;

   typedef struct packed {
      logic [7:0]       cfg_two;
      logic [7:0]       cfg_three;
      logic [7:0]       cfg_four;
      logic [7:0]       aux_cfg;
      logic [7:0]       main_cfg;
      logic [7:0]       pair_cfg;
      logic [1:0]       ref_sync;
      logic [1:0]       strap_sync;
      logic [1:0]       strap_wait;
      route_t [4:0]     route_prev;
      logic [4:0]       clk_q;
      logic [2:0]       comp_phase;
      logic             line_q;
      logic             comp_out;
      logic             line_out;
      logic             f2k_out;
      logic             f8k_out;
      logic [31:0]      rdata;
      logic             slverr;
   } top_state_t;

endpackage

// ===== hw/tick_divider.sv
/*
   Toggle divider: the output flips after every ratio input ticks.
   Assumes tick is a one-cycle enable on pclk and ratio is at least one.
*/
`timescale 1ns/1ps
module tick_divider #(
   parameter int unsigned WIDTH = 16
) (
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             tick,
   input  wire logic             restart,
   input  wire logic [WIDTH-1:0] ratio,
   output logic                  q
);
   typedef struct packed {
      logic [WIDTH-1:0] cnt;
      logic             q;
   } div_state_t;

   div_state_t s;
   div_state_t next_s;

   if (WIDTH < 2) begin : g_check
      $error("tick_divider WIDTH must be at least 2");
   end

   always_comb begin
      next_s = s;
      if (restart) begin
         next_s = '0;
      end else if (tick) begin
         if (s.cnt >= ratio - 1'b1) begin
            next_s.cnt = '0;
            next_s.q   = ~s.q;
         end else begin
            next_s.cnt = s.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign q = s.q;
endmodule // tick_divider

// ===== hw/output_clock_select.sv
/*
   Output clock selection for outputs three to eleven, with its APB
   register file. PLL rates arrive as one-cycle half-period ticks on pclk;
   synthesizer rates arrive as pclk-domain levels. The reference-valid flag
   and the strap pin are asynchronous and are synchronised here.
*/
`timescale 1ns/1ps
`include "output_clock_select_consts.svh"
module output_clock_select #(
   parameter int unsigned FRAME_2K_HALF = `PCLK_HZ / (2 * `FRAME_2K_HZ),
   parameter int unsigned FRAME_8K_HALF = `PCLK_HZ / (2 * `FRAME_8K_HZ)
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [9:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   input  wire logic        main_apll_tick,
   input  wire logic        aux_apll_tick,
   input  wire logic        digital_synth_one,
   input  wire logic        digital_synth_two,
   input  wire logic        aux_line_tick_e1,
   input  wire logic        aux_line_tick_t1,
   input  wire logic        main_line_tick,
   input  wire logic        aux_comp_tick,
   input  wire logic        main_comp_tick,
   input  wire logic        aux_ref_valid,
   input  wire logic        sonet_strap_pin,
   output logic             clk_out_three,
   output logic             clk_out_four,
   output logic             clk_out_five,
   output logic             clk_out_six,
   output logic             clk_out_seven,
   output logic             composite_clk_out,
   output logic             composite_clk_oe,
   output logic             line_rate_clk_out,
   output logic             frame_8k_out,
   output logic             frame_2k_out
);
   localparam int OUT_FOUR  = 1;
   localparam int OUT_FIVE  = 2;
   localparam int OUT_SIX   = 3;
   localparam int OUT_SEVEN = 4;

   output_clock_select_pkg::top_state_t s;
   output_clock_select_pkg::top_state_t next_s;

   output_clock_select_pkg::route_t [4:0] route;
   logic [4:0]  restart;
   logic [4:0]  div_tick;
   logic [4:0]  div_q;
   logic [3:0]  sel [5];
   logic        sq_2k;
   logic        sq_8k;
   logic        div10;
   logic        pair_aux;
   logic        mute;
   logic [7:0]  reg_idx;

   if (FRAME_2K_HALF < 1 || FRAME_2K_HALF > 65535 ||
       FRAME_8K_HALF < 1 || FRAME_8K_HALF > 65535) begin : g_check
      $error("frame half periods must fit in 16 bits and be nonzero");
   end

   // ----------------------------------------------------------------------
   // Selector decoding
   // ----------------------------------------------------------------------
   // Maps a selector code to a source and divide ratio. Ratios count
   // half-period ticks, so a ratio of one reproduces the PLL rate.
   function automatic output_clock_select_pkg::route_t decode_route(
      input logic [3:0] code,
      input int         idx,
      input logic       div_ten);
      output_clock_select_pkg::route_t r;
      r.kind  = output_clock_select_pkg::SRC_LOW;
      r.ratio = 16'h0000;
      case (code)
         `SEL_2K: begin
            r.kind = output_clock_select_pkg::SRC_2K;
         end
         `SEL_8K: begin
            r.kind = output_clock_select_pkg::SRC_8K;
         end
         `SEL_SYN_TWO: begin
            if (idx == OUT_SIX) begin
               r.kind  = output_clock_select_pkg::SRC_MAIN;
               r.ratio = 16'h0002;
            end else begin
               r.kind = output_clock_select_pkg::SRC_SYN_TWO;
            end
         end
         `SEL_SYN_ONE: begin
            if (idx == OUT_SEVEN) begin
               r.kind  = output_clock_select_pkg::SRC_MAIN;
               r.ratio = 16'h0002;
            end else begin
               r.kind = output_clock_select_pkg::SRC_SYN_ONE;
            end
         end
         `SEL_MAIN_48: begin
            r.kind  = output_clock_select_pkg::SRC_MAIN;
            r.ratio = (idx == OUT_SIX) ? 16'h0001 : 16'h0030;
         end
         `SEL_MAIN_16: begin
            r.kind  = output_clock_select_pkg::SRC_MAIN;
            r.ratio = 16'h0010;
         end
         `SEL_MAIN_12: begin
            r.kind  = output_clock_select_pkg::SRC_MAIN;
            r.ratio = 16'h000C;
         end
         `SEL_MAIN_8: begin
            r.kind  = output_clock_select_pkg::SRC_MAIN;
            r.ratio = 16'h0008;
         end
         `SEL_MAIN_6: begin
            r.kind  = output_clock_select_pkg::SRC_MAIN;
            r.ratio = 16'h0006;
         end
         `SEL_MAIN_4: begin
            r.kind  = output_clock_select_pkg::SRC_MAIN;
            r.ratio = 16'h0004;
         end
         `SEL_AUX_64: begin
            r.kind  = output_clock_select_pkg::SRC_AUX;
            r.ratio = (idx == OUT_FOUR || idx == OUT_FIVE) ? 16'h0002 : 16'h0040;
         end
         `SEL_AUX_48: begin
            r.kind  = output_clock_select_pkg::SRC_AUX;
            r.ratio = div_ten ? 16'h000A : 16'h0030;
         end
         `SEL_AUX_16: begin
            r.kind  = output_clock_select_pkg::SRC_AUX;
            r.ratio = 16'h0010;
         end
         `SEL_AUX_8: begin
            r.kind  = output_clock_select_pkg::SRC_AUX;
            r.ratio = 16'h0008;
         end
         `SEL_AUX_4: begin
            r.kind  = output_clock_select_pkg::SRC_AUX;
            r.ratio = 16'h0004;
         end
         default: begin
            r.kind = output_clock_select_pkg::SRC_LOW;
         end
      endcase
      return r;
   endfunction

   // True for every index that the register file answers.
   function automatic logic reg_hit(input logic [7:0] idx);
      return idx == `IDX_OUTPUT_CONFIG_TWO || idx == `IDX_OUTPUT_CONFIG_THREE ||
             idx == `IDX_OUTPUT_CONFIG_FOUR || idx == `IDX_AUX_PLL_CONFIG_ONE ||
             idx == `IDX_MAIN_PLL_CONFIG_ONE || idx == `IDX_MASTER_CONFIG_FOUR ||
             idx == `IDX_OUTPUT_STATUS;
   endfunction

   // ----------------------------------------------------------------------
   // Source conditions
   // ----------------------------------------------------------------------
   assign reg_idx  = paddr[9:2];
   assign div10    = s.aux_cfg[3:0] == `AUX_DPLL_62M5 &&
                     !s.main_cfg[`AUX_FROM_MAIN_BIT];
   assign pair_aux = !s.pair_cfg[`PAIR_SOURCE_BIT];
   assign mute     = pair_aux && s.aux_cfg[`AUTO_MUTE_BIT] && !s.ref_sync[1];

   assign sel[0] = s.cfg_two[3:0];
   assign sel[1] = s.cfg_two[7:4];
   assign sel[2] = s.cfg_three[3:0];
   assign sel[3] = s.cfg_three[7:4];
   assign sel[4] = s.cfg_four[3:0];

   // ----------------------------------------------------------------------
   // Per-output dividers
   // ----------------------------------------------------------------------
   for (genvar i = 0; i < 5; i++) begin : g_out
      assign route[i]    = decode_route(sel[i], i, div10);
      assign restart[i]  = route[i] != s.route_prev[i];
      assign div_tick[i] = (route[i].kind == output_clock_select_pkg::SRC_MAIN) ?
                           main_apll_tick : aux_apll_tick;
      tick_divider #(.WIDTH(16)) u_div (
         .pclk    (pclk),
         .presetn (presetn),
         .tick    (div_tick[i]),
         .restart (restart[i]),
         .ratio   (route[i].ratio),
         .q       (div_q[i])
      );
   end

   tick_divider #(.WIDTH(16)) u_frame_2k (
      .pclk    (pclk),
      .presetn (presetn),
      .tick    (1'b1),
      .restart (1'b0),
      .ratio   (16'(FRAME_2K_HALF)),
      .q       (sq_2k)
   );

   tick_divider #(.WIDTH(16)) u_frame_8k (
      .pclk    (pclk),
      .presetn (presetn),
      .tick    (1'b1),
      .restart (1'b0),
      .ratio   (16'(FRAME_8K_HALF)),
      .q       (sq_8k)
   );

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      next_s            = s;
      next_s.ref_sync   = {s.ref_sync[0], aux_ref_valid};
      next_s.strap_sync = {s.strap_sync[0], sonet_strap_pin};

      // The strap is caught once the synchroniser holds a settled value.
      if (s.strap_wait != 2'h3) begin
         next_s.strap_wait = s.strap_wait + 2'h1;
         if (s.strap_wait == 2'h2) begin
            next_s.aux_cfg[`SONET_SEL_BIT] = s.strap_sync[1];
         end
      end

      // Read data and error are prepared in the setup phase.
      if (psel && !penable) begin
         next_s.slverr = !reg_hit(reg_idx) || paddr[1:0] != 2'h0;
         case (reg_idx)
            `IDX_OUTPUT_CONFIG_TWO:   next_s.rdata = {24'h000000, s.cfg_two};
            `IDX_OUTPUT_CONFIG_THREE: next_s.rdata = {24'h000000, s.cfg_three};
            `IDX_OUTPUT_CONFIG_FOUR:  next_s.rdata = {24'h000000, s.cfg_four};
            `IDX_AUX_PLL_CONFIG_ONE:  next_s.rdata = {24'h000000, s.aux_cfg};
            `IDX_MAIN_PLL_CONFIG_ONE: next_s.rdata = {24'h000000, s.main_cfg};
            `IDX_MASTER_CONFIG_FOUR:  next_s.rdata = {24'h000000, s.pair_cfg};
            `IDX_OUTPUT_STATUS: begin
               next_s.rdata = {29'h00000000, div10, mute, s.ref_sync[1]};
            end
            default: next_s.rdata = 32'h00000000;
         endcase
      end

      // A write lands after the strap capture, so software wins that edge.
      if (psel && penable && pwrite && pstrb[0] && !s.slverr) begin
         case (reg_idx)
            `IDX_OUTPUT_CONFIG_TWO:   next_s.cfg_two   = pwdata[7:0];
            `IDX_OUTPUT_CONFIG_THREE: next_s.cfg_three = pwdata[7:0];
            `IDX_OUTPUT_CONFIG_FOUR:  next_s.cfg_four  = pwdata[7:0];
            `IDX_AUX_PLL_CONFIG_ONE: begin
               next_s.aux_cfg = pwdata[7:0] & `AUX_CFG_WRITE_MASK;
            end
            `IDX_MAIN_PLL_CONFIG_ONE: next_s.main_cfg = pwdata[7:0];
            `IDX_MASTER_CONFIG_FOUR: begin
               next_s.pair_cfg = pwdata[7:0] & `PAIR_CFG_WRITE_MASK;
            end
            default: next_s.main_cfg = s.main_cfg;
         endcase
      end

      // General-purpose outputs, each on its own divider.
      for (int i = 0; i < 5; i++) begin
         next_s.route_prev[i] = route[i];
         case (route[i].kind)
            output_clock_select_pkg::SRC_2K:      next_s.clk_q[i] = sq_2k;
            output_clock_select_pkg::SRC_8K:      next_s.clk_q[i] = sq_8k;
            output_clock_select_pkg::SRC_SYN_ONE: next_s.clk_q[i] = digital_synth_one;
            output_clock_select_pkg::SRC_SYN_TWO: next_s.clk_q[i] = digital_synth_two;
            output_clock_select_pkg::SRC_MAIN:    next_s.clk_q[i] = div_q[i];
            output_clock_select_pkg::SRC_AUX:     next_s.clk_q[i] = div_q[i];
            default:                              next_s.clk_q[i] = 1'b0;
         endcase
      end

      // Line-rate clock: E1 or T1 rate from the selected pair source.
      if (pair_aux ? (s.aux_cfg[`SONET_SEL_BIT] ? aux_line_tick_t1 : aux_line_tick_e1)
                   : main_line_tick) begin
         next_s.line_q = ~s.line_q;
      end
      next_s.line_out = s.cfg_four[`LINE_RATE_EN_BIT] && !mute && s.line_q;

      // Composite clock: eight phases per period, high for four or five.
      if (pair_aux ? aux_comp_tick : main_comp_tick) begin
         next_s.comp_phase = s.comp_phase + 3'h1;
      end
      next_s.comp_out = !mute && s.cfg_four[`COMPOSITE_EN_BIT] &&
                        s.comp_phase < (s.aux_cfg[`DUTY_SEL_BIT] ?
                                        `COMP_HIGH_5_8 : `COMP_HIGH_HALF);

      next_s.f2k_out = s.cfg_four[`FRAME_2K_EN_BIT] && sq_2k;
      next_s.f8k_out = s.cfg_four[`FRAME_8K_EN_BIT] && sq_8k;
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s           <= '0;
         s.cfg_two   <= `RST_OUTPUT_CONFIG_TWO;
         s.cfg_three <= `RST_OUTPUT_CONFIG_THREE;
         s.cfg_four  <= `RST_OUTPUT_CONFIG_FOUR;
         s.aux_cfg   <= `RST_AUX_PLL_CONFIG_ONE;
         s.main_cfg  <= `RST_MAIN_PLL_CONFIG_ONE;
         s.pair_cfg  <= `RST_MASTER_CONFIG_FOUR;
      end else begin
         s <= next_s;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign pready            = 1'b1;
   assign prdata            = s.rdata;
   assign pslverr           = s.slverr;
   assign clk_out_three     = s.clk_q[0];
   assign clk_out_four      = s.clk_q[1];
   assign clk_out_five      = s.clk_q[2];
   assign clk_out_six       = s.clk_q[3];
   assign clk_out_seven     = s.clk_q[4];
   assign composite_clk_out = s.comp_out;
   assign composite_clk_oe  = s.cfg_four[`COMPOSITE_EN_BIT];
   assign line_rate_clk_out = s.line_out;
   assign frame_8k_out      = s.f8k_out;
   assign frame_2k_out      = s.f2k_out;
endmodule // output_clock_select

// ===== tb/clock_sink.sv
/*
   Downstream receiver model: measures high and low run lengths of one
   picked output clock. Assumes outputs settle before the falling edge.
*/
`timescale 1ns/1ps
module clock_sink (
   input  wire logic       pclk,
   input  wire logic [8:0] taps,
   input  wire logic [3:0] pick,
   output int              hi,
   output int              lo,
   output int              run,
   output logic            cur
);
   initial begin
      hi = 0;
      lo = 0;
      run = 0;
      cur = 1'b0;
   end
   always @(negedge pclk) begin
      if (taps[pick] === cur) begin
         run++;
      end else begin
         if (cur) hi = run;
         else lo = run;
         cur = taps[pick];
         run = 1;
      end
   end
endmodule // clock_sink

// ===== tb/output_clock_select_checker.sv
/*
   Checker of the output clock selection block, bound to its top module.
   Assumes zero-wait APB with byte address four times the index.
*/
`timescale 1ns/1ps
module output_clock_select_checker (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic [9:0]  paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire logic        aux_ref_valid,
   input wire logic        composite_clk_oe,
   input wire logic        composite_clk_out,
   input wire logic        line_rate_clk_out,
   input wire logic        frame_8k_out,
   input wire logic        frame_2k_out
);
   logic [7:0] en_cfg;
   logic       mute_on;
   logic       pair_main;
   logic [2:0] ref_low;
   wire        wr    = psel & penable & pwrite & pstrb[0];
   wire        rd    = psel & ~penable & ~pwrite;
   wire        muted = mute_on & ~pair_main & (ref_low > 3'h4);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_cfg    <= 8'hF6;
         mute_on   <= 1'b0;
         pair_main <= 1'b0;
         ref_low   <= 3'h0;
      end else begin
         if (wr && paddr == 10'h18C) en_cfg <= pwdata[7:0];
         if (wr && paddr == 10'h190) mute_on <= pwdata[6];
         if (wr && paddr == 10'h1C0) pair_main <= pwdata[0];
         ref_low <= aux_ref_valid ? 3'h0 : ref_low + {2'h0, ref_low != 3'h7};
      end
   end
   chk_oe_follows:
   assert property (wr && paddr == 10'h18C |=> composite_clk_oe == $past(pwdata[4]))
      else $error("Composite enable differs from its register bit.");
   chk_frame2k_off:
   assert property (!en_cfg[7] && !$past(en_cfg[7]) |-> !frame_2k_out)
      else $error("Disabled 2 kHz frame output is not low.");
   chk_frame8k_off:
   assert property (!en_cfg[6] && !$past(en_cfg[6]) |-> !frame_8k_out)
      else $error("Disabled 8 kHz frame output is not low.");
   chk_line_off:
   assert property (!en_cfg[5] && !$past(en_cfg[5]) |-> !line_rate_clk_out)
      else $error("Disabled line-rate output is not low.");
   chk_mute_low:
   assert property (muted && $past(muted) |-> !line_rate_clk_out && !composite_clk_out)
      else $error("Muted outputs are not low.");
   chk_read_back:
   assert property (rd && paddr == 10'h18C |=> prdata == {24'h000000, en_cfg})
      else $error("Read data differs from the last write.");
   chk_bad_index:
   assert property (psel && !penable && paddr[9:2] == 8'h50 |=> pslverr && prdata == 32'h0)
      else $error("Unmapped index not refused.");
   chk_upper_zero:
   assert property (rd |=> prdata[31:8] == 24'h000000)
      else $error("Upper read data bits not zero.");
   cov_mute: cover property (muted);
   cov_cfg_write: cover property (wr && paddr == 10'h18C);
   cov_bad_index: cover property (rd && paddr[9:2] == 8'h50);
endmodule // output_clock_select_checker

bind output_clock_select output_clock_select_checker u_checker (
   .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
   .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
   .pslverr(pslverr), .aux_ref_valid(aux_ref_valid), .composite_clk_oe(composite_clk_oe),
   .composite_clk_out(composite_clk_out), .line_rate_clk_out(line_rate_clk_out),
   .frame_8k_out(frame_8k_out), .frame_2k_out(frame_2k_out)
);

// ===== tb/output_clock_select_bench.sv
/*
   Bench of the output clock selection block: APB register traffic and
   run-length checks of every output. Assumes frame halves of 10 and 4.
*/
`timescale 1ns/1ps
module output_clock_select_bench;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        rd_err, oe, ref_ok, strap, cur;
   logic [9:0]  paddr;
   logic [31:0] pwdata, prdata, rd_data;
   logic [3:0]  pstrb, pick;
   logic [6:0]  tk;
   logic [1:0]  syn;
   logic [8:0]  taps;
   int          cnt, mismatches, samples_checked, hi, lo, run;
   logic [7:0]  ridx[6] = '{8'h61, 8'h62, 8'h63, 8'h64, 8'h65, 8'h70};
   logic [7:0]  rval[6] = '{8'h86, 8'h8A, 8'hF6, 8'h11, 8'h01, 8'h00};
   int          h3[16]  = '{0, 10, 4, 8, 4, 48, 16, 12, 8, 6, 4, 128, 96, 32, 16, 8};
   logic [7:0]  oidx[9] = '{8'h61, 8'h62, 8'h62, 8'h62, 8'h62, 8'h63, 8'h63, 8'h61, 8'h62};
   logic [7:0]  oval[9] = '{8'hB0, 8'h0B, 8'h30, 8'h50, 8'h40, 8'hF4, 8'hF3, 8'h30, 8'h04};
   int          otap[9] = '{1, 2, 3, 3, 3, 4, 4, 1, 2};
   int          oh[9]   = '{4, 4, 2, 1, 4, 2, 8, 8, 4};

   output_clock_select #(.FRAME_2K_HALF(10), .FRAME_8K_HALF(4)) dut (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .main_apll_tick(tk[0]), .aux_apll_tick(tk[1]),
      .digital_synth_one(syn[0]), .digital_synth_two(syn[1]), .aux_line_tick_e1(tk[2]),
      .aux_line_tick_t1(tk[3]), .main_line_tick(tk[4]), .aux_comp_tick(tk[5]),
      .main_comp_tick(tk[6]), .aux_ref_valid(ref_ok), .sonet_strap_pin(strap),
      .clk_out_three(taps[0]), .clk_out_four(taps[1]), .clk_out_five(taps[2]),
      .clk_out_six(taps[3]), .clk_out_seven(taps[4]), .composite_clk_out(taps[5]),
      .composite_clk_oe(oe), .line_rate_clk_out(taps[6]), .frame_8k_out(taps[7]),
      .frame_2k_out(taps[8]));
   clock_sink sink (.pclk(pclk), .taps(taps), .pick(pick), .hi(hi), .lo(lo), .run(run),
      .cur(cur));

   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   // Ticks at spacings that differ within each set of alternatives (main/aux PLL, E1/T1/main line, aux/main composite).
   always @(posedge pclk) begin
      cnt <= cnt + 1;
      tk  <= {cnt % 2 == 0, 1'b1, cnt % 7 == 0, cnt % 5 == 0, cnt % 3 == 0, cnt % 2 == 0, 1'b1};
      syn <= {cnt[3], cnt[2]};
   end

   // ----------------------------------------------------------------
   // Bus and check tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= {idx, 2'b00};
      pwdata  <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd_data = prdata;
      rd_err  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d);
   endtask
   task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
      apb(1'b0, idx, 8'h00);
      chk(rd_data, {24'h000000, exp});
   endtask
   task automatic meas(input int p, input int h, input int l);
      pick <= p[3:0];
      repeat (8 * h + 40) @(posedge pclk);
      chk(hi, h);
      chk(lo, l);
   endtask
   task automatic quiet(input int p);
      pick <= p[3:0];
      repeat (300) @(posedge pclk);
      chk({cur, run >= 250}, 32'h1);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge pclk);
      mismatches++;
      summarize();
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, pick} = '0;
      pstrb = 4'hF;
      ref_ok = 1'b1;
      strap = 1'b1;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      foreach (ridx[i]) rd(ridx[i], rval[i]);
      pstrb <= 4'hE;
      wr(8'h61, 8'h55);
      pstrb <= 4'hF;
      rd(8'h61, 8'h86);
      apb(1'b0, 8'h50, 8'h00);
      chk(rd_err, 1'b1);
      for (int c = 0; c < 16; c++) begin
         wr(8'h61, c[7:0]);
         rd(8'h61, c[7:0]);
         if (c == 0) quiet(0);
         else meas(0, h3[c], h3[c]);
      end
      foreach (oidx[i]) begin
         wr(oidx[i], oval[i]);
         meas(otap[i], oh[i], oh[i]);
      end
      wr(8'h64, 8'h09);
      rd(8'h71, 8'h05);
      wr(8'h61, 8'h0C);
      meas(0, 20, 20);
      wr(8'h65, 8'h41);
      meas(0, 96, 96);
      wr(8'h65, 8'h01);
      meas(5, 4, 4);
      meas(6, 3, 3);
      wr(8'h64, 8'h39);
      meas(5, 5, 3);
      meas(6, 5, 5);
      wr(8'h70, 8'h01);
      meas(6, 7, 7);
      wr(8'h70, 8'h00);
      wr(8'h63, 8'h06);
      @(negedge pclk);
      chk(oe, 1'b0);
      quiet(6);
      quiet(7);
      quiet(8);
      wr(8'h63, 8'hF6);
      @(negedge pclk);
      chk(oe, 1'b1);
      meas(8, 10, 10);
      meas(7, 4, 4);
      wr(8'h64, 8'h49);
      ref_ok <= 1'b0;
      quiet(5);
      quiet(6);
      rd(8'h71, 8'h06);
      ref_ok <= 1'b1;
      meas(6, 3, 3);
      summarize();
   end
endmodule // output_clock_select_bench
